// file: bench/bad_core_assertions.sv
`default_nettype none
module bad_core_assertions
    import bad_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Request
    input  wire logic       opValid,
    input  wire bad_op_t    opKind,
    input  wire bad_src_t   opSrc,
    input  wire logic       targetIsPort,
    input  wire logic [1:0] portSel,
    // Operands and flags in
    input  wire logic [7:0] accIn,
    input  wire logic [7:0] regIn,
    input  wire logic [7:0] portLatch0,
    input  wire logic       carryIn,
    input  wire logic       auxCarryIn,
    input  wire logic       overflowIn,
    // Results
    input  wire logic [7:0] resultOut,
    input  wire logic       carryOut,
    input  wire logic       auxCarryOut,
    input  wire logic       overflowOut
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire fx = opValid && opKind == BAD_OP_FIXUP;
    wire mn = opValid && opKind == BAD_OP_MINUS;
    AST_LO: assert property (fx && accIn[3:0] > 4'h9 |=>
        resultOut[3:0] == $past(accIn[3:0]) + 4'h6) else $error("low digit");
    AST_AUX: assert property (fx && auxCarryIn |=>
        resultOut[3:0] == $past(accIn[3:0]) + 4'h6) else $error("aux digit");
    AST_HI: assert property (fx && accIn[7:4] > 4'h9 |=> carryOut)
        else $error("overflow");
    AST_CY: assert property (fx && (carryIn || accIn[7:4] == 4'h9 && accIn[3:0] > 4'h9)
        |=> carryOut) else $error("carry");
    AST_DEC: assert property (mn && opSrc == BAD_SRC_ACC |=>
        resultOut == $past(accIn) - 8'h01) else $error("decrement");
    AST_FLG: assert property (mn |=> carryOut == $past(carryIn) &&
        auxCarryOut == $past(auxCarryIn) && overflowOut == $past(overflowIn)) else $error("flags");
    AST_REG: assert property (mn && opSrc == BAD_SRC_REG |=>
        resultOut == $past(regIn) - 8'h01) else $error("register");
    AST_PRT: assert property (mn && opSrc == BAD_SRC_DIRECT && targetIsPort && !portSel |=>
        resultOut == $past(portLatch0) - 8'h01) else $error("latch");
    cover property (fx && carryIn);
    cover property (mn && targetIsPort);
    cover property (mn && accIn == 8'h00);
    cover property (fx && auxCarryIn);
endmodule
bind bad_core bad_core_assertions i_chk (
    .mclk         (mclk),
    .nrst         (nrst),
    .opValid      (opValid),
    .opKind       (opKind),
    .opSrc        (opSrc),
    .targetIsPort (targetIsPort),
    .portSel      (portSel),
    .accIn        (accIn),
    .regIn        (regIn),
    .portLatch0   (portLatch0),
    .carryIn      (carryIn),
    .auxCarryIn   (auxCarryIn),
    .overflowIn   (overflowIn),
    .resultOut    (resultOut),
    .carryOut     (carryOut),
    .auxCarryOut  (auxCarryOut),
    .overflowOut  (overflowOut)
);
`default_nettype wire

// file: bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns / 1ps;
    import bad_pkg::*;
    logic mclk = 0, nrst = 0, opValid = 0, targetIsPort = 0, carryIn = 0, auxCarryIn = 0;
    logic overflowIn = 0, resultValid, carryOut, auxCarryOut, overflowOut;
    bad_op_t opKind = BAD_OP_NONE;
    bad_src_t opSrc = BAD_SRC_ACC, resultDest;
    logic [1:0] portSel = 0;
    logic [7:0] accIn = 8'h00, regIn = 8'h00, directIn = 8'h00, indirectIn = 8'h00;
    logic [7:0] resultOut, a, b, p;
    logic [7:0] portLatch0 = 8'h00, portLatch1 = 8'h01, portLatch2 = 8'h02, portLatch3 = 8'h03;
    logic [7:0] mask [4] = '{8'h00, 8'h5a, 8'ha5, 8'h3c};
    logic [12:0] q[$];
    int n_fail = 0, checked = 0, cyc = 0;
    wire [12:0] seen = {resultDest, carryOut, auxCarryOut, overflowOut, resultOut};
    bad_core i_dut (
        .mclk         (mclk),
        .nrst         (nrst),
        .opValid      (opValid),
        .opKind       (opKind),
        .opSrc        (opSrc),
        .targetIsPort (targetIsPort),
        .portSel      (portSel),
        .accIn        (accIn),
        .regIn        (regIn),
        .directIn     (directIn),
        .indirectIn   (indirectIn),
        .portLatch0   (portLatch0),
        .portLatch1   (portLatch1),
        .portLatch2   (portLatch2),
        .portLatch3   (portLatch3),
        .carryIn      (carryIn),
        .auxCarryIn   (auxCarryIn),
        .overflowIn   (overflowIn),
        .resultOut    (resultOut),
        .resultDest   (resultDest),
        .resultValid  (resultValid),
        .carryOut     (carryOut),
        .auxCarryOut  (auxCarryOut),
        .overflowOut  (overflowOut)
    );
    always #2 mclk = ~mclk;
    task automatic chk(logic [12:0] got, logic [12:0] exp);
        checked++;
        n_fail += int'(got !== exp);
        if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic tally_and_finish();
        n_fail += int'(cyc > 200);
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Source follows the low operand bits, so one stream covers all four sources.
    task automatic go(bad_op_t k, logic [7:0] v, logic [5:0] f, logic [10:0] e);
        @(negedge mclk);
        opKind = k;
        opSrc = bad_src_t'(v[1:0]);
        // Each source carries its own value, so a wrong source select shows up.
        accIn = v ^ mask[0];
        regIn = v ^ mask[1];
        directIn = v ^ mask[2];
        indirectIn = v ^ mask[3];
        {carryIn, auxCarryIn, overflowIn, targetIsPort, portSel} = f;
        if (k != BAD_OP_NONE) q.push_back({k == BAD_OP_FIXUP ? BAD_SRC_ACC : opSrc, e});
    endtask
    always @(posedge mclk) begin
        if (++cyc > 200) begin
            tally_and_finish();
        end else if (resultValid === 1'b1) begin
            if (q.size() == 0) chk(13'h1, 13'h0);
            else chk(seen, q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h3f60ef37));
        repeat (5) @(negedge mclk);
        {nrst, opValid} = 2'b11;
        go(BAD_OP_MINUS, 8'h00, 6'h38, {3'h7, 8'hff});
        repeat (40) begin
            {a, p} = 16'($urandom);
            b = a[1:0] == 2'h2 && p[2] ? 8'(p[1:0]) : a ^ mask[a[1:0]];
            go(BAD_OP_MINUS, a, p[5:0], {p[5:3], b - 8'h01});
        end
        go(BAD_OP_FIXUP, 8'hbe, 6'h00, {3'h4, 8'h24});
        go(BAD_OP_FIXUP, 8'h12, 6'h20, {3'h4, 8'h72});
        go(BAD_OP_FIXUP, 8'h40, 6'h10, {3'h2, 8'h46});
        go(BAD_OP_FIXUP, 8'h9a, 6'h08, {3'h5, 8'h00});
        go(BAD_OP_FIXUP, 8'hfa, 6'h00, {3'h4, 8'h60});
        go(BAD_OP_FIXUP, 8'hc9, 6'h00, {3'h4, 8'h29});
        go(BAD_OP_NONE, 8'h45, 6'h00, 11'h0);
        repeat (3) @(negedge mclk);
        chk(13'(q.size()), 13'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: hdl/bad_core.sv
`include "bad_map.svh"
`default_nettype none
module bad_core
    import bad_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Operation request
    input  wire logic       opValid,
    input  wire bad_op_t    opKind,
    input  wire bad_src_t   opSrc,
    input  wire logic       targetIsPort,
    input  wire logic [1:0] portSel,
    // Operand sources
    input  wire logic [7:0] accIn,
    input  wire logic [7:0] regIn,
    input  wire logic [7:0] directIn,
    input  wire logic [7:0] indirectIn,
    input  wire logic [7:0] portLatch0,
    input  wire logic [7:0] portLatch1,
    input  wire logic [7:0] portLatch2,
    input  wire logic [7:0] portLatch3,
    // Status flags in
    input  wire logic       carryIn,
    input  wire logic       auxCarryIn,
    input  wire logic       overflowIn,
    // Result
    output logic      [7:0] resultOut,
    output bad_src_t        resultDest,
    output logic            resultValid,
    output logic            carryOut,
    output logic            auxCarryOut,
    output logic            overflowOut
);
    logic       doFixup;
    logic       doMinus;

    logic [7:0] portVal;
    logic [7:0] operand;
    logic [7:0] minusVal;

    logic [7:0] fixAcc;
    logic       fixCarry;

    logic [7:0] result_q;
    logic [7:0] result_d;

    bad_src_t   dest_q;
    bad_src_t   dest_d;

    logic       valid_q;
    logic       valid_d;

    logic       carry_q;
    logic       carry_d;

    logic       aux_q;
    logic       aux_d;

    logic       ovf_q;
    logic       ovf_d;

    bad_fixup uFixup (
        .accIn      (accIn),
        .carryIn    (carryIn),
        .auxCarryIn (auxCarryIn),
        .accOut     (fixAcc),
        .carryOut   (fixCarry)
    );

    // An undefined operation code is dropped here, so it never pulses a result.
    always_comb begin
        doFixup = 1'b0;
        doMinus = 1'b0;
        if (opValid) begin
            case (opKind)
                BAD_OP_FIXUP: begin
                    doFixup = 1'b1;
                end
                BAD_OP_MINUS: begin
                    doMinus = 1'b1;
                end
                default: begin
                    doFixup = 1'b0;
                    doMinus = 1'b0;
                end
            endcase
        end
    end

    // Ports are read from their latch so pin loading cannot corrupt the value.
    always_comb begin
        case (portSel)
            2'h0: begin
                portVal = portLatch0;
            end
            2'h1: begin
                portVal = portLatch1;
            end
            2'h2: begin
                portVal = portLatch2;
            end
            default: begin
                portVal = portLatch3;
            end
        endcase
    end

    always_comb begin
        case (opSrc)
            BAD_SRC_ACC: begin
                operand = accIn;
            end
            BAD_SRC_REG: begin
                operand = regIn;
            end
            BAD_SRC_DIRECT: begin
                if (targetIsPort) begin
                    operand = portVal;
                end else begin
                    operand = directIn;
                end
            end
            default: begin
                operand = indirectIn;
            end
        endcase
    end

    // Plain modulo arithmetic gives the wrap from zero to all ones for free.
    always_comb begin
        minusVal = operand - `BAD_BYTE_ONE;
    end

    always_comb begin
        result_d = result_q;
        if (doFixup) begin
            result_d = fixAcc;
        end else if (doMinus) begin
            result_d = minusVal;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            result_q <= `BAD_RESULT_RESET;
        end else begin
            result_q <= result_d;
        end
    end

    always_comb begin
        dest_d = dest_q;
        if (doFixup) begin
            dest_d = BAD_SRC_ACC;
        end else if (doMinus) begin
            dest_d = opSrc;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dest_q <= BAD_SRC_ACC;
        end else begin
            dest_q <= dest_d;
        end
    end

    // One pulse per taken request; requests may arrive on every cycle.
    always_comb begin
        valid_d = doFixup | doMinus;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
        end
    end

    // Carry tracks its input except on a fix-up, which may only raise it.
    always_comb begin
        carry_d = carryIn;
        if (doFixup) begin
            carry_d = fixCarry;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            carry_q <= `BAD_FLAG_RESET;
        end else begin
            carry_q <= carry_d;
        end
    end

    // Neither operation may alter these flags, so they simply track their inputs.
    always_comb begin
        aux_d = auxCarryIn;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            aux_q <= `BAD_FLAG_RESET;
        end else begin
            aux_q <= aux_d;
        end
    end

    always_comb begin
        ovf_d = overflowIn;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ovf_q <= `BAD_FLAG_RESET;
        end else begin
            ovf_q <= ovf_d;
        end
    end

    // Every output comes straight from a flip-flop.
    assign resultOut   = result_q;
    assign resultDest  = dest_q;
    assign resultValid = valid_q;
    assign carryOut    = carry_q;
    assign auxCarryOut = aux_q;
    assign overflowOut = ovf_q;
endmodule
`default_nettype wire

// file: hdl/bad_fixup.sv
`include "bad_map.svh"
`default_nettype none
module bad_fixup (
    // Operand and flags in
    input  wire logic [7:0] accIn,
    input  wire logic       carryIn,
    input  wire logic       auxCarryIn,
    // Result
    output logic      [7:0] accOut,
    output logic            carryOut
);
    logic [8:0] lowSum;
    logic [8:0] highSum;
    logic       lowCarry;
    always_comb begin
        lowSum = {1'b0, accIn};
        if (accIn[3:0] > `BAD_DIGIT_MAX || auxCarryIn) begin
            lowSum = {1'b0, accIn} + {5'h00, `BAD_DIGIT_FIX};
        end
        // A carry out of the low correction ripples into carry.
        lowCarry = lowSum[8] | carryIn;
        highSum = {1'b0, lowSum[7:0]};
        if (lowSum[7:4] > `BAD_DIGIT_MAX || lowCarry) begin
            highSum = {1'b0, lowSum[7:0]} + {1'b0, `BAD_DIGIT_FIX, 4'h0};
        end
        accOut = highSum[7:0];
        // Carry is only ever set, so a decimal overflow is never lost.
        carryOut = lowCarry | highSum[8];
    end
endmodule
`default_nettype wire

// file: hdl/bad_map.svh
`ifndef BAD_MAP_SVH
`define BAD_MAP_SVH
`define BAD_DIGIT_MAX   4'h9
`define BAD_DIGIT_FIX   4'h6
`define BAD_BYTE_ONE    8'h01
`define BAD_PORT_COUNT  4
`define BAD_RESULT_RESET 8'h00
`define BAD_FLAG_RESET   1'b0
`endif

// file: hdl/bad_pkg.sv
`default_nettype none
package bad_pkg;
    typedef enum logic [1:0] {
        BAD_SRC_ACC,
        BAD_SRC_REG,
        BAD_SRC_DIRECT,
        BAD_SRC_INDIRECT
    } bad_src_t;
    typedef enum logic [1:0] {
        BAD_OP_NONE,
        BAD_OP_FIXUP,
        BAD_OP_MINUS
    } bad_op_t;
endpackage
`default_nettype wire
